// >>> verilog/sprite_params.svh
// constants for the sprite three control block and its controller
`ifndef SPRITE_PARAMS_SVH
`define SPRITE_PARAMS_SVH

`define CTL_OFFSET 32'h0007_2380
`define CTL_RESET 32'h0000_0000
`define CTL_WMASK 32'hfc7f_8404
`define SURF_RESET 32'h0000_0000
`define COLOR_RESET 32'h0000_0000

`define CTL_EN_BIT 31
`define CTL_GAMMA_BIT 30
`define CTL_FMT_LSB 26
`define CTL_PIPE_LSB 24
`define CTL_KEY_BIT 22
`define CTL_DUP_LSB 20
`define CTL_CSC_BYP_BIT 19
`define CTL_CSC709_BIT 18
`define CTL_ORDER_LSB 16
`define CTL_ROT_BIT 15
`define CTL_TILED_BIT 10
`define CTL_BOTTOM_BIT 2

`define FMT_YUV422 4'h0
`define FMT_IDX8 4'h2
`define FMT_BGR565 4'h5
`define FMT_BGRX8888 4'h6
`define FMT_BGRA8888 4'h7
`define FMT_RGBX1010102 4'h8
`define FMT_RGBA1010102 4'h9
`define FMT_RGBX8888 4'he
`define FMT_RGBA8888 4'hf

`define SEL_CONTROL 2'h0
`define SEL_SURFACE 2'h1
`define SEL_COLOR 2'h2

`define HOST_DATA 8'h00
`define HOST_CMD 8'h04
`define HOST_READBACK 8'h08
`define HOST_STATUS 8'h0c

`endif

// >>> verilog/sprite_pkg.sv
// types shared by both ends of the sprite three control link
package sprite_pkg;

   typedef struct packed {
      logic [31:0] pend_ctl;
      logic [31:0] act_ctl;
      logic [31:0] pend_surf;
      logic [31:0] act_surf;
      logic [31:0] color_adj;
      logic armed;
      logic loaded;
      logic [31:0] rdata;
      logic plane_on;
      logic fetch_en;
      logic [9:0] pix_r;
      logic [9:0] pix_g;
      logic [9:0] pix_b;
      logic pix_valid;
   } dev_state_t;

   typedef struct packed {
      logic [31:0] data;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic wr;
      logic [1:0] sel;
      logic [31:0] wdata;
      logic [7:0] load_count;
   } host_state_t;

endpackage : sprite_pkg

// >>> verilog/sprite_link_if.sv
// link between the register controller and the sprite three control bank
`timescale 1ns/1ns
`default_nettype none

interface sprite_link_if;
   logic reg_wr;
   logic [1:0] reg_sel;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic upd_armed;
   logic upd_loaded;

   modport dev_end (
      input reg_wr,
      input reg_sel,
      input reg_wdata,
      output reg_rdata,
      output upd_armed,
      output upd_loaded
   );

   modport host_end (
      output reg_wr,
      output reg_sel,
      output reg_wdata,
      input reg_rdata,
      input upd_armed,
      input upd_loaded
   );
endinterface : sprite_link_if

`default_nettype wire

// >>> verilog/pix_widen.sv
// widens a source pixel of any supported format to 10 bits per component
`timescale 1ns/1ns
`default_nettype none
`include "sprite_params.svh"

module pix_widen (
   input wire logic [3:0] fmt,
   input wire logic [1:0] yuv_order,
   input wire logic [31:0] src,
   output logic [9:0] r,
   output logic [9:0] g,
   output logic [9:0] b
);
   logic [7:0] y0;
   logic [7:0] u;
   logic [7:0] v;

   // byte order of packed 4:2:2, only first luma sample kept
   always_comb begin
      y0 = src[7:0];
      u = src[15:8];
      v = src[31:24];
      unique case (yuv_order)
         2'h0: begin
            y0 = src[7:0];
            u = src[15:8];
            v = src[31:24];
         end
         2'h1: begin
            u = src[7:0];
            y0 = src[15:8];
            v = src[23:16];
         end
         2'h2: begin
            y0 = src[7:0];
            v = src[15:8];
            u = src[31:24];
         end
         2'h3: begin
            v = src[7:0];
            y0 = src[15:8];
            u = src[23:16];
         end
      endcase
   end

   always_comb begin
      r = 10'h000;
      g = 10'h000;
      b = 10'h000;
      case (fmt)
         `FMT_YUV422: begin
            r = {v, v[7:6]};
            g = {y0, y0[7:6]};
            b = {u, u[7:6]};
         end
         `FMT_IDX8: begin
            r = {src[7:0], src[7:6]};
            g = {src[7:0], src[7:6]};
            b = {src[7:0], src[7:6]};
         end
         `FMT_BGR565: begin
            r = {src[15:11], src[15:11]};
            g = {src[10:5], src[10:7]};
            b = {src[4:0], src[4:0]};
         end
         `FMT_BGRX8888, `FMT_BGRA8888: begin
            r = {src[23:16], src[23:22]};
            g = {src[15:8], src[15:14]};
            b = {src[7:0], src[7:6]};
         end
         `FMT_RGBX1010102, `FMT_RGBA1010102: begin
            r = src[9:0];
            g = src[19:10];
            b = src[29:20];
         end
         `FMT_RGBX8888, `FMT_RGBA8888: begin
            r = {src[7:0], src[7:6]};
            g = {src[15:8], src[15:14]};
            b = {src[23:16], src[23:22]};
         end
         default: begin
            r = 10'h000;
            g = 10'h000;
            b = 10'h000;
         end
      endcase
   end
endmodule : pix_widen

`default_nettype wire

// >>> verilog/sprite_ctrl_dev.sv
// sprite three control register with double-buffered update and pixel widening
// Behaviour
// R1: pending copy loads active at armed vblank
// R2: surface write or enable rise arms update
// R3: colour adjust writes apply at once
// R4: pipe two off: use other vblank
// R5: software keeps a pipe running first
// R6: enable drives fetch and pixel output
// R7: trusted: ignore enable, off when unlocked
// R8: bit 30 routes through pipe gamma
// R9: software: gamma bit per trust, format
// R10: field 29:26 selects source format
// R11: every format widened to ten bits
// R12: bit 22 enables source keying
// R13: field 21:20 selects line/pixel doubling
// R14: bit 19 bypasses YUV conversion
// R15: bit 18 picks 601 or 709
// R16: field 17:16 YUV byte order
// R17: bit 15 rotates plane 180 degrees
// R18: bit 10 selects X-tiled memory
// R19: bit 2 forces bottom z-order
// R20: pipe select field has no effect
// R21: reserved bits read zero, read pending
`timescale 1ns/1ns
`default_nettype none
`include "sprite_params.svh"

module sprite_ctrl_dev (
   input wire logic pclk,
   input wire logic presetn,
   sprite_link_if.dev_end lnk,
   input wire logic pipe_a_running,
   input wire logic pipe_b_running,
   input wire logic vblank_a,
   input wire logic vblank_b,
   input wire logic plane_trusted,
   input wire logic regs_unlocked,
   input wire logic [31:0] src_pixel,
   input wire logic src_valid,
   output logic plane_on,
   output logic fetch_en,
   output logic pipe_gamma_en,
   output logic [3:0] src_format,
   output logic src_key_en,
   output logic [1:0] dup_mode,
   output logic csc_bypass,
   output logic csc_bt709,
   output logic [1:0] yuv_order,
   output logic rotate_180,
   output logic x_tiled,
   output logic force_bottom,
   output logic [31:0] surface_base,
   output logic [31:0] color_adjust,
   output logic [9:0] pix_r,
   output logic [9:0] pix_g,
   output logic [9:0] pix_b,
   output logic pix_valid
);
   import sprite_pkg::*;

   dev_state_t s_q;
   dev_state_t s_d;
   logic [31:0] new_ctl;
   logic vblank_sel;
   logic [9:0] w_r;
   logic [9:0] w_g;
   logic [9:0] w_b;

   // R11 widening of the active format
   pix_widen u_widen (
      .fmt(s_q.act_ctl[`CTL_FMT_LSB +: 4]),
      .yuv_order(s_q.act_ctl[`CTL_ORDER_LSB +: 2]),
      .src(src_pixel),
      .r(w_r),
      .g(w_g),
      .b(w_b)
   );

   // R20 pipe select and reserved bits dropped on write
   // R21 reserved bits never stored
   assign new_ctl = lnk.reg_wdata & `CTL_WMASK;

   // R4 fall back to the other pipe's vblank
   assign vblank_sel = pipe_b_running ? vblank_b : vblank_a;

   always_comb begin
      s_d = s_q;
      s_d.loaded = 1'b0;

      // R1 atomic load of pending into active
      if (vblank_sel && s_q.armed) begin
         s_d.act_ctl = s_q.pend_ctl;
         s_d.act_surf = s_q.pend_surf;
         s_d.armed = 1'b0;
         s_d.loaded = 1'b1;
      end

      // arming after the load so a same-cycle trigger is kept
      if (lnk.reg_wr) begin
         unique case (lnk.reg_sel)
            `SEL_CONTROL: begin
               // R2 enable rising edge is a trigger
               if (!s_q.pend_ctl[`CTL_EN_BIT] && new_ctl[`CTL_EN_BIT]) begin
                  s_d.armed = 1'b1;
               end
               // R6 disable also blanks at next vblank
               if (s_q.pend_ctl[`CTL_EN_BIT] && !new_ctl[`CTL_EN_BIT]) begin
                  s_d.armed = 1'b1;
               end
               s_d.pend_ctl = new_ctl;
            end
            `SEL_SURFACE: begin
               // R2 start address write is a trigger
               s_d.pend_surf = lnk.reg_wdata;
               s_d.armed = 1'b1;
            end
            `SEL_COLOR: begin
               // R3 colour adjust bypasses buffering
               s_d.color_adj = lnk.reg_wdata;
            end
            default: begin
               s_d.color_adj = s_q.color_adj;
            end
         endcase
      end

      // R21 read returns pending copy
      s_d.rdata = s_d.pend_ctl;

      // R7 trusted plane follows the lock
      // R6 enable gates fetch and output
      if (plane_trusted) begin
         s_d.plane_on = !regs_unlocked;
      end else begin
         s_d.plane_on = s_d.act_ctl[`CTL_EN_BIT];
      end
      s_d.fetch_en = s_d.plane_on;

      // R6 blanked output when off
      if (s_q.plane_on && src_valid) begin
         s_d.pix_r = w_r;
         s_d.pix_g = w_g;
         s_d.pix_b = w_b;
         s_d.pix_valid = 1'b1;
      end else begin
         s_d.pix_r = 10'h000;
         s_d.pix_g = 10'h000;
         s_d.pix_b = 10'h000;
         s_d.pix_valid = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.pend_ctl <= `CTL_RESET;
         s_q.act_ctl <= `CTL_RESET;
         s_q.pend_surf <= `SURF_RESET;
         s_q.act_surf <= `SURF_RESET;
         s_q.color_adj <= `COLOR_RESET;
         s_q.armed <= 1'b0;
         s_q.loaded <= 1'b0;
         s_q.rdata <= `CTL_RESET;
         s_q.plane_on <= 1'b0;
         s_q.fetch_en <= 1'b0;
         s_q.pix_r <= 10'h000;
         s_q.pix_g <= 10'h000;
         s_q.pix_b <= 10'h000;
         s_q.pix_valid <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign lnk.reg_rdata = s_q.rdata;
   assign lnk.upd_armed = s_q.armed;
   assign lnk.upd_loaded = s_q.loaded;

   assign plane_on = s_q.plane_on;
   assign fetch_en = s_q.fetch_en;
   // R8 pipe gamma routing
   assign pipe_gamma_en = s_q.act_ctl[`CTL_GAMMA_BIT];
   // R10 source format code
   assign src_format = s_q.act_ctl[`CTL_FMT_LSB +: 4];
   // R12 keying enable to blender
   assign src_key_en = s_q.act_ctl[`CTL_KEY_BIT];
   // R13 doubling mode
   assign dup_mode = s_q.act_ctl[`CTL_DUP_LSB +: 2];
   // R14 conversion bypass
   assign csc_bypass = s_q.act_ctl[`CTL_CSC_BYP_BIT];
   // R15 colour standard
   assign csc_bt709 = s_q.act_ctl[`CTL_CSC709_BIT];
   // R16 byte order
   assign yuv_order = s_q.act_ctl[`CTL_ORDER_LSB +: 2];
   // R17 rotation
   assign rotate_180 = s_q.act_ctl[`CTL_ROT_BIT];
   // R18 tiling select
   assign x_tiled = s_q.act_ctl[`CTL_TILED_BIT];
   // R19 bottom of z-order
   assign force_bottom = s_q.act_ctl[`CTL_BOTTOM_BIT];
   assign surface_base = s_q.act_surf;
   assign color_adjust = s_q.color_adj;
   assign pix_r = s_q.pix_r;
   assign pix_g = s_q.pix_g;
   assign pix_b = s_q.pix_b;
   assign pix_valid = s_q.pix_valid;
endmodule : sprite_ctrl_dev

`default_nettype wire

// >>> verilog/sprite_ctrl_host.sv
// apb register controller that drives the sprite three control link
`timescale 1ns/1ns
`default_nettype none
`include "sprite_params.svh"

module sprite_ctrl_host #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   sprite_link_if.host_end lnk
);
   import sprite_pkg::*;

   host_state_t s_q;
   host_state_t s_d;
   logic access;
   logic [7:0] addr;

   assign addr = paddr[7:0];
   // one wait state, request taken when pready is seen high
   assign access = psel && penable && s_q.pready;

   always_comb begin
      s_d = s_q;
      s_d.wr = 1'b0;
      s_d.pready = psel && penable && !s_q.pready;
      if (lnk.upd_loaded) begin
         s_d.load_count = s_q.load_count + 8'h01;
      end
      if (psel && penable && !s_q.pready) begin
         s_d.pslverr = 1'b0;
         unique case (addr)
            `HOST_DATA: s_d.prdata = s_q.data;
            `HOST_CMD: s_d.prdata = 32'h0000_0000;
            `HOST_READBACK: s_d.prdata = lnk.reg_rdata;
            `HOST_STATUS: s_d.prdata = {16'h0000, s_q.load_count, 7'h00, lnk.upd_armed};
            default: begin
               s_d.prdata = 32'h0000_0000;
               s_d.pslverr = 1'b1;
            end
         endcase
      end
      // data staging and command to the link
      if (access && pwrite) begin
         if (addr == `HOST_DATA) begin
            s_d.data = pwdata;
         end
         if (addr == `HOST_CMD) begin
            s_d.wr = 1'b1;
            s_d.sel = pwdata[1:0];
            s_d.wdata = s_q.data;
         end
      end
      // error flag stands only with pready
      if (s_q.pready) begin
         s_d.pslverr = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.data <= 32'h0000_0000;
         s_q.prdata <= 32'h0000_0000;
         s_q.pready <= 1'b0;
         s_q.pslverr <= 1'b0;
         s_q.wr <= 1'b0;
         s_q.sel <= `SEL_CONTROL;
         s_q.wdata <= 32'h0000_0000;
         s_q.load_count <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign lnk.reg_wr = s_q.wr;
   assign lnk.reg_sel = s_q.sel;
   assign lnk.reg_wdata = s_q.wdata;
endmodule : sprite_ctrl_host

`default_nettype wire

// >>> test/sprite_link_props.sv
// assertions on the link between controller and sprite three control bank
`timescale 1ns/1ns
`default_nettype none

module sprite_link_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic reg_wr,
   input wire logic [1:0] reg_sel,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic upd_armed,
   input wire logic upd_loaded
);
   logic ctl_wr;
   assign ctl_wr = reg_wr && reg_sel == 2'h0;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   mask_rd_a: assert property (ctl_wr |=> reg_rdata == ($past(reg_wdata) & 32'hfc7f8404))
      else $error("readback differs from masked write");
   resv_zero_a: assert property ((reg_rdata & 32'h03807bfb) == 32'h0)
      else $error("reserved readback bit set");
   rd_hold_a: assert property (!ctl_wr |=> $stable(reg_rdata))
      else $error("readback moved without control write");
   surf_arm_a: assert property (reg_wr && reg_sel == 2'h1 |=> upd_armed)
      else $error("start address write did not arm");
   en_arm_a: assert property (ctl_wr && !reg_rdata[31] && reg_wdata[31] |=> upd_armed)
      else $error("enable rise did not arm");
   arm_cause_a: assert property ($rose(upd_armed) |-> $past(reg_wr) && $past(reg_sel) != 2'h2)
      else $error("armed without trigger");
   color_free_a: assert property (reg_wr && reg_sel == 2'h2 && !upd_armed |=> !upd_armed)
      else $error("colour write armed an update");
   load_armed_a: assert property (upd_loaded |-> $past(upd_armed))
      else $error("load without trigger");
   arm_hold_a: assert property (upd_armed |=> upd_armed || upd_loaded)
      else $error("armed dropped without load");
   load_pulse_a: assert property (upd_loaded |=> !upd_loaded)
      else $error("load flag longer than one cycle");

   cover property (upd_loaded);
   cover property (reg_wr && reg_sel == 2'h2);
   cover property (upd_armed [*3]);
endmodule : sprite_link_props

`default_nettype wire

// >>> test/sprite_plane_control_dbuf_tb.sv
// self-checking bench for controller and sprite three control bank together
`timescale 1ns/1ns
`default_nettype none

module sprite_plane_control_dbuf_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, surface_base, color_adjust, got_f;
   logic er, pa, pb, va, vb, trusted, unlocked, src_valid, plane_on, fetch_en, pix_valid;
   logic [31:0] src_pixel;
   logic pipe_gamma_en, src_key_en, csc_bypass, csc_bt709, rotate_180, x_tiled, force_bottom;
   logic [3:0] src_format;
   logic [1:0] dup_mode, yuv_order;
   logic [9:0] pix_r, pix_g, pix_b;
   logic [7:0] loads;
   int bad_count, n_checks;
   sprite_link_if lnk ();
   sprite_ctrl_host #(.ADDR_W(8)) sprite_ctrl_host_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
   sprite_ctrl_dev sprite_ctrl_dev_i (.pclk(pclk), .presetn(presetn), .lnk(lnk),
      .pipe_a_running(pa), .pipe_b_running(pb), .vblank_a(va), .vblank_b(vb),
      .plane_trusted(trusted), .regs_unlocked(unlocked), .src_pixel(src_pixel),
      .src_valid(src_valid), .plane_on(plane_on), .fetch_en(fetch_en),
      .pipe_gamma_en(pipe_gamma_en), .src_format(src_format), .src_key_en(src_key_en),
      .dup_mode(dup_mode), .csc_bypass(csc_bypass), .csc_bt709(csc_bt709),
      .yuv_order(yuv_order), .rotate_180(rotate_180), .x_tiled(x_tiled),
      .force_bottom(force_bottom), .surface_base(surface_base), .color_adjust(color_adjust),
      .pix_r(pix_r), .pix_g(pix_g), .pix_b(pix_b), .pix_valid(pix_valid));
   sprite_link_props sprite_link_props_i (.pclk(pclk), .presetn(presetn),
      .reg_wr(lnk.reg_wr), .reg_sel(lnk.reg_sel), .reg_wdata(lnk.reg_wdata),
      .reg_rdata(lnk.reg_rdata), .upd_armed(lnk.upd_armed), .upd_loaded(lnk.upd_loaded));

   assign got_f = {17'h0, pipe_gamma_en, src_format, src_key_en, dup_mode, csc_bypass,
      csc_bt709, yuv_order, rotate_180, x_tiled, force_bottom};

   function automatic logic [31:0] fld(input logic [31:0] c);
      return {17'h0, c[30], c[29:26], c[22], c[21:20], c[19], c[18], c[17:16], c[15],
         c[10], c[2]};
   endfunction : fld

   task automatic close_out;
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready, prdata and pslverr as sampled at this edge
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic cfg(input logic [1:0] sel, input logic [31:0] d);
      apb(1'b1, 8'h00, d);
      apb(1'b1, 8'h04, {30'h0, sel});
   endtask : cfg

   task automatic settle;
      repeat (3) @(negedge pclk);
   endtask : settle

   task automatic stat(input logic armed);
      apb(1'b0, 8'h0c, 32'h0);
      chk("status", {16'h0, loads, 7'h0, armed}, rd & 32'h0000ff01);
   endtask : stat

   task automatic pulse(input logic on_b, input logic loads_now);
      @(posedge pclk);
      va <= !on_b;
      vb <= on_b;
      @(posedge pclk);
      va <= 1'b0;
      vb <= 1'b0;
      loads = loads + {7'h0, loads_now};
      settle();
   endtask : pulse

   // expected word is {0, valid, r, g, b}
   task automatic pix(input logic [31:0] e);
      @(posedge pclk);
      src_valid <= 1'b1;
      @(posedge pclk);
      src_valid <= 1'b0;
      @(negedge pclk);
      chk("pixel", e, {1'b0, pix_valid, pix_r, pix_g, pix_b});
   endtask : pix

   task automatic s_pending;
      cfg(2'h0, 32'h7bffffff);
      apb(1'b0, 8'h08, 32'h0);
      chk("readback", 32'h787f8404, rd);
      pulse(1'b1, 1'b0);
      chk("fields", 32'h0, got_f);
      stat(1'b0);
      cfg(2'h1, 32'h00012000);
      stat(1'b1);
      chk("fields", 32'h0, got_f);
      pulse(1'b1, 1'b1);
      chk("fields", fld(32'h787f8404), got_f);
      chk("surface", 32'h00012000, surface_base);
      stat(1'b0);
   endtask : s_pending

   task automatic s_enable;
      @(posedge pclk);
      pb <= 1'b0;
      cfg(2'h0, 32'ha0000000);
      stat(1'b1);
      pulse(1'b1, 1'b0);
      chk("plane on", 32'h0, {31'h0, plane_on});
      pulse(1'b0, 1'b1);
      chk("plane on", 32'h3, {30'h0, plane_on, fetch_en});
      pix(32'h6784_5523);
      @(posedge pclk);
      pb <= 1'b1;
   endtask : s_enable

   task automatic s_formats;
      logic [3:0] codes [9] = '{4'h0, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'he, 4'hf};
      foreach (codes[i]) begin
         cfg(2'h0, {1'b1, codes[i] == 4'h2, codes[i], 26'h0});
         cfg(2'h1, 32'h0);
         pulse(1'b1, 1'b1);
         chk("format", {28'h0, codes[i]}, {28'h0, src_format});
      end
   endtask : s_formats

   task automatic s_disable_trust;
      cfg(2'h0, 32'h0);
      settle();
      chk("plane on", 32'h1, {31'h0, plane_on});
      pulse(1'b1, 1'b1);
      chk("plane on", 32'h0, {30'h0, plane_on, fetch_en});
      pix(32'h0);
      @(posedge pclk);
      trusted <= 1'b1;
      settle();
      chk("trusted", 32'h1, {31'h0, plane_on});
      @(posedge pclk);
      unlocked <= 1'b1;
      settle();
      chk("trusted", 32'h0, {31'h0, plane_on});
      @(posedge pclk);
      trusted <= 1'b0;
      unlocked <= 1'b0;
   endtask : s_disable_trust

   task automatic s_color_refuse;
      cfg(2'h2, 32'h01234567);
      settle();
      chk("colour", 32'h01234567, color_adjust);
      stat(1'b0);
      apb(1'b0, 8'h10, 32'h0);
      chk("error", 32'h1, {31'h0, er});
      apb(1'b1, 8'h08, 32'hffffffff);
      apb(1'b0, 8'h08, 32'h0);
      chk("readback", 32'h0, rd);
   endtask : s_color_refuse

   initial begin
      pclk = 1'b0;
      forever #50 pclk = !pclk;
   end

   initial begin
      repeat (6000) @(posedge pclk);
      bad_count++;
      close_out();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {va, vb, trusted, unlocked, src_valid} = '0;
      src_pixel = 32'h1234_5678;
      pa = 1'b1;
      pb = 1'b1;
      loads = 8'h0;
      bad_count = 0;
      n_checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h08, 32'h0);
      chk("readback", 32'h0, rd);
      stat(1'b0);
      chk("fields", 32'h0, got_f);
      s_pending();
      s_enable();
      s_formats();
      s_disable_trust();
      s_color_refuse();
      close_out();
   end
endmodule : sprite_plane_control_dbuf_tb

`default_nettype wire
